/* File: rtl/tmr_consts.vh */
// register indexes, field positions and reset values of the timer flag block
`ifndef TMR_CONSTS_VH
`define TMR_CONSTS_VH

// register indexes; byte address is four times the index
`define TMR_IDX_CNT_HI   6'h04
`define TMR_IDX_CNT_LO   6'h05
`define TMR_IDX_SC1      6'h06
`define TMR_IDX_EDGE_HI  6'h0A
`define TMR_IDX_EDGE_LO  6'h0B
`define TMR_IDX_IEN      6'h0C
`define TMR_IDX_SC2      6'h0D
`define TMR_IDX_FLG1     6'h0E
`define TMR_IDX_FLG2     6'h0F
`define TMR_IDX_CH_FIRST 6'h10
`define TMR_IDX_CH_LAST  6'h1F

// system_control_one fields
`define TMR_SC1_RUN      7
`define TMR_SC1_FAST     4
`define TMR_SC1_FINE     3
// system_control_two fields
`define TMR_SC2_OVF_IE   7
`define TMR_SC2_DIV_MSB  2
// overflow_flags field
`define TMR_FLG2_WRAP    7

// reset values
`define TMR_RST_BYTE     8'h00
`define TMR_RST_WORD     16'h0000
`define TMR_RST_DIV      3'h0

// counter limits
`define TMR_CNT_MAX      16'hFFFF

// bus answers
`define TMR_RESP_OKAY    2'h0
`define TMR_RESP_SLVERR  2'h2

`endif

/* File: rtl/tmr_prescaler.v */
// power-of-two prescaler of the timer counter clock
`timescale 1ns/10ps
`include "tmr_consts.vh"

module tmr_prescaler (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       run,
    input  wire [2:0] div_sel,
    output reg        tick_reg
);

    reg  [6:0] stage_reg;
    reg  [2:0] active_sel_reg;
    wire [6:0] low_mask;
    wire       last_stage;

    // only the stages below the divider matter for the tick
    assign low_mask   = ~(7'h7F << active_sel_reg);
    assign last_stage = ((stage_reg & low_mask) == low_mask);

    // stage chain; new select taken while every stage is zero, and on every cycle while run is low
    always @(posedge aclk) begin
        if (!aresetn) begin
            stage_reg      <= 7'h00;
            active_sel_reg <= `TMR_RST_DIV;
            tick_reg       <= 1'b0;
        end else if (!run) begin
            stage_reg      <= 7'h00;
            active_sel_reg <= div_sel;
            tick_reg       <= 1'b0;
        end else begin
            stage_reg <= stage_reg + 7'h01;
            tick_reg  <= last_stage;
            if (stage_reg == 7'h00) begin
                active_sel_reg <= div_sel;
            end
        end
    end

endmodule

/* File: rtl/tmr_top.v */
// register block, flags, edge detectors and counter of the two-channel timer
`timescale 1ns/10ps
`include "tmr_consts.vh"

// Functional notes
// - edge field picks none, rising, falling, both
// - absent channel bits ignore writes, read zero
// - channel enables gate channel flags onto interrupt
// - overflow enable gates overflow flag onto interrupt
// - divider select gives clock divided by power-of-two
// - new divider applies when prescaler stages zero
// - capture or compare event sets channel flag
// - writing one clears flag only while running
// - writing zero leaves flag unchanged
// - fast mode clears flag on channel access
// - counter wrap to zero sets overflow flag
// - overflow flag cleared by one while running
// - fast mode clears overflow on counter access
// - run bit zero stops timer and counter
// - fast clear bit selects access-based clearing
// - fine mode bit off uses coarse divider
module tmr_top (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [1:0]  capture_pin,
    input  wire [1:0]  channel_is_compare,
    input  wire [1:0]  compare_event,
    input  wire        fine_tick,
    output reg         irq_reg
);

    // software registers
    reg  [7:0]  system_control_one_reg;
    reg  [3:0]  edge_control_low_reg;
    reg  [1:0]  channel_irq_enable_reg;
    reg         overflow_irq_enable_reg;
    reg  [2:0]  clock_divider_select_reg;
    reg  [1:0]  channel_event_flag_reg;
    reg         counter_wrap_flag_reg;
    reg  [15:0] free_running_counter_reg;
    reg  [15:0] capture_value_reg [0:1];
    reg         fine_written_reg;

    // bus state
    reg  [5:0]  aw_idx_reg;
    reg         aw_got_reg;
    reg  [7:0]  w_byte_reg;
    reg         w_lane0_reg;
    reg         w_got_reg;

    // pin sampling
    reg  [1:0]  pin_meta_reg;
    reg  [1:0]  pin_sync_reg;
    reg  [1:0]  pin_prev_reg;

    wire        timer_run;
    wire        fast_flag_clear;
    wire        fine_divider_mode;
    wire        coarse_tick;
    wire        count_tick;
    wire        wr_fire;
    wire        rd_fire;
    wire [5:0]  ar_idx;
    wire        wr_en;
    wire [1:0]  rise;
    wire [1:0]  fall;
    wire [1:0]  capture_hit;
    wire [1:0]  fast_clr_ch;
    wire [1:0]  sw_clr_ch;
    wire [1:0]  flag_set;
    wire        wrap_set;
    wire        wrap_clr;
    wire        wr_ch_win;
    wire        rd_ch_win;
    wire        wr_cnt;
    wire        rd_cnt;

    assign timer_run         = system_control_one_reg[`TMR_SC1_RUN];
    assign fast_flag_clear   = system_control_one_reg[`TMR_SC1_FAST];
    assign fine_divider_mode = system_control_one_reg[`TMR_SC1_FINE];

    // coarse divider; held still while the timer is off to save power
    tmr_prescaler tmr_prescaler_inst (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .run      (timer_run),
        .div_sel  (clock_divider_select_reg),
        .tick_reg (coarse_tick)
    );

    // fine divider lives outside this block and hands in its tick
    assign count_tick = timer_run & (fine_divider_mode ? fine_tick : coarse_tick);

    // handshakes
    assign wr_fire = aw_got_reg & w_got_reg & ~s_axi_bvalid;
    assign wr_en   = wr_fire & w_lane0_reg;
    assign rd_fire = s_axi_arvalid & s_axi_arready;
    assign ar_idx  = s_axi_araddr[7:2];

    // channel window decode: two bytes per channel, only channels 0 and 1 exist
    assign wr_ch_win = wr_en & (aw_idx_reg >= `TMR_IDX_CH_FIRST) & (aw_idx_reg <= `TMR_IDX_CH_LAST);
    assign rd_ch_win = rd_fire & (ar_idx >= `TMR_IDX_CH_FIRST) & (ar_idx <= `TMR_IDX_CH_LAST);
    assign wr_cnt    = wr_fire & ((aw_idx_reg == `TMR_IDX_CNT_HI) | (aw_idx_reg == `TMR_IDX_CNT_LO));
    assign rd_cnt    = rd_fire & ((ar_idx == `TMR_IDX_CNT_HI) | (ar_idx == `TMR_IDX_CNT_LO));

    // capture pins: two flops, then a third copy for edge history
    always @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta_reg <= 2'h0;
            pin_sync_reg <= 2'h0;
            pin_prev_reg <= 2'h0;
        end else begin
            pin_meta_reg <= capture_pin;
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    assign rise = pin_sync_reg & ~pin_prev_reg;
    assign fall = ~pin_sync_reg & pin_prev_reg;

    // per-channel edge detect, flag set and clear terms
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
            assign capture_hit[ch] = timer_run & ~channel_is_compare[ch] &
                ((edge_control_low_reg[2*ch] & rise[ch]) |
                 (edge_control_low_reg[2*ch+1] & fall[ch]));
            assign flag_set[ch] = capture_hit[ch] |
                (timer_run & channel_is_compare[ch] & compare_event[ch]);
            assign fast_clr_ch[ch] = fast_flag_clear & (
                (rd_ch_win & ~channel_is_compare[ch] & (ar_idx[3:1] == ch)) |
                (wr_ch_win & channel_is_compare[ch] & (aw_idx_reg[3:1] == ch)));
            assign sw_clr_ch[ch] = wr_en & timer_run & (aw_idx_reg == `TMR_IDX_FLG1) &
                w_byte_reg[ch];

            // latch counter on the chosen edge
            always @(posedge aclk) begin
                if (!aresetn) begin
                    capture_value_reg[ch] <= `TMR_RST_WORD;
                end else if (capture_hit[ch]) begin
                    capture_value_reg[ch] <= free_running_counter_reg;
                end
            end
        end
    endgenerate

    // a set arriving with a clear wins
    always @(posedge aclk) begin
        if (!aresetn) begin
            channel_event_flag_reg <= 2'h0;
        end else begin
            channel_event_flag_reg <= (channel_event_flag_reg & ~(sw_clr_ch | fast_clr_ch)) | flag_set;
        end
    end

    // free-running counter, frozen while off; bus writes to it have no effect
    always @(posedge aclk) begin
        if (!aresetn) begin
            free_running_counter_reg <= `TMR_RST_WORD;
        end else if (count_tick) begin
            free_running_counter_reg <= free_running_counter_reg + 16'h0001;
        end
    end

    assign wrap_set = count_tick & (free_running_counter_reg == `TMR_CNT_MAX);
    assign wrap_clr = (wr_en & timer_run & (aw_idx_reg == `TMR_IDX_FLG2) & w_byte_reg[`TMR_FLG2_WRAP]) |
                      (fast_flag_clear & (wr_cnt | rd_cnt));

    // overflow flag, set wins
    always @(posedge aclk) begin
        if (!aresetn) begin
            counter_wrap_flag_reg <= 1'b0;
        end else begin
            counter_wrap_flag_reg <= (counter_wrap_flag_reg & ~wrap_clr) | wrap_set;
        end
    end

    // interrupt line, registered so it never glitches
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= (|(channel_event_flag_reg & channel_irq_enable_reg)) |
                       (counter_wrap_flag_reg & overflow_irq_enable_reg);
        end
    end

    // write address and data may arrive in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg    <= 1'b0;
            aw_idx_reg    <= 6'h00;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid & s_axi_awready) begin
            aw_got_reg    <= 1'b1;
            aw_idx_reg    <= s_axi_awaddr[7:2];
            s_axi_awready <= 1'b0;
        end else if (wr_fire) begin
            aw_got_reg    <= 1'b0;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= ~aw_got_reg & ~s_axi_bvalid;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            w_got_reg    <= 1'b0;
            w_byte_reg   <= `TMR_RST_BYTE;
            w_lane0_reg  <= 1'b0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid & s_axi_wready) begin
            w_got_reg    <= 1'b1;
            w_byte_reg   <= s_axi_wdata[7:0];
            w_lane0_reg  <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
        end else if (wr_fire) begin
            w_got_reg    <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= ~w_got_reg & ~s_axi_bvalid;
        end
    end

    // write response; only an index beyond the channel window answers with a slave error
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `TMR_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_idx_reg > `TMR_IDX_CH_LAST) ? `TMR_RESP_SLVERR : `TMR_RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // control register writes; only byte lane 0 carries data
    always @(posedge aclk) begin
        if (!aresetn) begin
            system_control_one_reg   <= `TMR_RST_BYTE;
            fine_written_reg         <= 1'b0;
            edge_control_low_reg     <= 4'h0;
            channel_irq_enable_reg   <= 2'h0;
            overflow_irq_enable_reg  <= 1'b0;
            clock_divider_select_reg <= `TMR_RST_DIV;
        end else if (wr_en) begin
            case (aw_idx_reg)
                `TMR_IDX_SC1: begin
                    // fine mode bit may be written once after reset
                    system_control_one_reg[`TMR_SC1_RUN]  <= w_byte_reg[`TMR_SC1_RUN];
                    system_control_one_reg[`TMR_SC1_FAST] <= w_byte_reg[`TMR_SC1_FAST];
                    fine_written_reg <= 1'b1;
                    if (!fine_written_reg) begin
                        system_control_one_reg[`TMR_SC1_FINE] <= w_byte_reg[`TMR_SC1_FINE];
                    end
                end
                `TMR_IDX_EDGE_LO: begin
                    edge_control_low_reg <= w_byte_reg[3:0];
                end
                `TMR_IDX_IEN: begin
                    channel_irq_enable_reg <= w_byte_reg[1:0];
                end
                `TMR_IDX_SC2: begin
                    overflow_irq_enable_reg  <= w_byte_reg[`TMR_SC2_OVF_IE];
                    clock_divider_select_reg <= w_byte_reg[`TMR_SC2_DIV_MSB:0];
                end
                default: begin
                    system_control_one_reg <= system_control_one_reg;
                end
            endcase
        end
    end

    // read mux; absent channel bits and the upper edge register read zero
    reg [7:0] rd_byte;
    reg       rd_bad;
    always @* begin
        rd_byte = `TMR_RST_BYTE;
        rd_bad  = 1'b0;
        case (ar_idx)
            `TMR_IDX_CNT_HI:  rd_byte = free_running_counter_reg[15:8];
            `TMR_IDX_CNT_LO:  rd_byte = free_running_counter_reg[7:0];
            `TMR_IDX_SC1:     rd_byte = system_control_one_reg;
            `TMR_IDX_EDGE_HI: rd_byte = `TMR_RST_BYTE;
            `TMR_IDX_EDGE_LO: rd_byte = {4'h0, edge_control_low_reg};
            `TMR_IDX_IEN:     rd_byte = {6'h00, channel_irq_enable_reg};
            `TMR_IDX_SC2:     rd_byte = {overflow_irq_enable_reg, 4'h0, clock_divider_select_reg};
            `TMR_IDX_FLG1:    rd_byte = {6'h00, channel_event_flag_reg};
            `TMR_IDX_FLG2:    rd_byte = {counter_wrap_flag_reg, 7'h00};
            6'h10:            rd_byte = capture_value_reg[0][15:8];
            6'h11:            rd_byte = capture_value_reg[0][7:0];
            6'h12:            rd_byte = capture_value_reg[1][15:8];
            6'h13:            rd_byte = capture_value_reg[1][7:0];
            default: begin
                rd_byte = `TMR_RST_BYTE;
                rd_bad  = (ar_idx > `TMR_IDX_CH_LAST);
            end
        endcase
    end

    // read channel: one transfer at a time, data one cycle after the address
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `TMR_RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h000000, rd_byte};
            s_axi_rresp   <= rd_bad ? `TMR_RESP_SLVERR : `TMR_RESP_OKAY;
        end else if (s_axi_rvalid) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= ~s_axi_rready;
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

endmodule

/* File: sim/tmr_chk.sv */
// port checks of the timer register block
`timescale 1ns/10ps
`include "tmr_consts.vh"

module tmr_chk (
    input logic        aclk,
    input logic        aresetn,
    input logic [7:0]  s_axi_awaddr,
    input logic [7:0]  s_axi_araddr,
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic [1:0]  s_axi_bresp,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic [31:0] s_axi_rdata,
    input logic        irq_reg
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [3:0] idle_reg;
    wire        w_hs  = (s_axi_awvalid & s_axi_awready) | (s_axi_wvalid & s_axi_wready);
    wire        ar_hs = s_axi_arvalid & s_axi_arready;
    wire [5:0]  ar_idx = s_axi_araddr[7:2];

    // cycles since the last bus handshake; flags only drop through the bus
    always @(posedge aclk) begin
        if (!aresetn || w_hs || ar_hs)
            idle_reg <= {4{!aresetn}};
        else
            idle_reg <= idle_reg + {3'h0, idle_reg != 4'hF};
    end

    chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped before bready");
    chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer changed before rready");
    chk_read_answer: assert property (ar_hs |=> s_axi_rvalid)
        else $error("read answer late");
    chk_write_cause: assert property ($rose(s_axi_bvalid) |-> $past(w_hs, 2))
        else $error("write answer without a handshake");
    chk_absent_high: assert property (ar_hs && ar_idx == `TMR_IDX_EDGE_HI |=> s_axi_rdata == 32'h0)
        else $error("absent edge field read nonzero");
    chk_absent_low: assert property (ar_hs && ar_idx == `TMR_IDX_EDGE_LO |=> s_axi_rdata[31:4] == 28'h0)
        else $error("absent channel edge bits nonzero");
    chk_enable_width: assert property (ar_hs && ar_idx == `TMR_IDX_IEN |=> s_axi_rdata[31:2] == 30'h0)
        else $error("enable read beyond two channels");
    chk_wrap_position: assert property (ar_hs && ar_idx == `TMR_IDX_FLG2 |=> s_axi_rdata[6:0] == 7'h0)
        else $error("overflow flag register low bits nonzero");
    chk_range_error: assert property (s_axi_awvalid && s_axi_awready && s_axi_awaddr[7:2] > `TMR_IDX_CH_LAST
        |-> ##[1:8] s_axi_bvalid && s_axi_bresp == `TMR_RESP_SLVERR)
        else $error("out of range write not refused");
    chk_irq_release: assert property ($fell(irq_reg) |-> idle_reg < 4'h4)
        else $error("interrupt dropped without bus access");
    chk_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq_reg)
        else $error("outputs active in reset");

    cover property ($rose(irq_reg));
    cover property ($fell(irq_reg));
    cover property (ar_hs && ar_idx == `TMR_IDX_FLG2);
endmodule

/* File: sim/tmr_top_bench.sv */
// self-checking bench of the timer register block
`timescale 1ns/10ps

module tmr_top_bench;
    logic        aclk = 1'b0, aresetn = 1'b0, fine_tick = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [1:0]  capture_pin = 2'h0, channel_is_compare = 2'h0, compare_event = 2'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_reg;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    int          num_errors = 0, n_compared = 0, cyc = 0;

    tmr_top tmr_top_inst (.*);

    always #5 aclk = ~aclk;

    // hang guard: one full counter wrap dominates the run
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 'h186A0) begin
            num_errors++;
            $display("CHECK FAILED at %0t: timeout", $time);
            complete_run;
        end
    end

    task complete_run;
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // address and data offered together, each dropped once taken
    task wr(input logic [5:0] i, input logic [7:0] d);
        @(posedge aclk);
        s_axi_awaddr <= {i, 2'b00};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        do @(posedge aclk); while (!s_axi_bvalid);
        chk({30'h0, s_axi_bresp}, (i > 6'h1F) ? 32'h2 : 32'h0, "write response");
        s_axi_bready <= 1'b0;
    endtask

    task rd(input logic [5:0] i, output logic [31:0] v);
        @(posedge aclk);
        s_axi_araddr <= {i, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        v = s_axi_rdata;
        chk({30'h0, s_axi_rresp}, 32'h0, "read response");
        s_axi_rready <= 1'b0;
    endtask

    task rdc(input logic [5:0] i, input logic [7:0] e);
        logic [31:0] v;
        rd(i, v);
        chk(v, {24'h0, e}, "register read");
    endtask

    // irq lags its flags by a cycle, so let two edges pass first
    task irq_is(input logic e);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq_reg}, {31'h0, e}, "irq level");
    endtask

    task pin0(input logic v);
        @(posedge aclk);
        capture_pin[0] <= v;
        repeat (6) @(posedge aclk);
    endtask

    task t_regs;
        for (int k = 10; k < 16; k++) rdc(k[5:0], 8'h00);
        wr(6'h0A, 8'hFF);
        rdc(6'h0A, 8'h00);
        wr(6'h0B, 8'hFF);
        rdc(6'h0B, 8'h0F);
        wr(6'h0C, 8'hFF);
        rdc(6'h0C, 8'h03);
        wr(6'h0D, 8'hFF);
        rdc(6'h0D, 8'h87);
        wr(6'h0E, 8'hFF);
        rdc(6'h0E, 8'h00);
        wr(6'h30, 8'hFF);
        wr(6'h0C, 8'h00);
        wr(6'h0D, 8'h00);
    endtask

    // every edge code, rise and fall judged apart on channel 0
    task t_edges;
        logic [2:0] c;
        wr(6'h06, 8'h80);
        for (c = 3'h0; c < 3'h4; c++) begin
            wr(6'h0B, {6'h00, c[1:0]});
            wr(6'h0E, 8'h03);
            pin0(1'b1);
            rdc(6'h0E, {7'h00, c[0]});
            wr(6'h0E, 8'h01);
            pin0(1'b0);
            rdc(6'h0E, {7'h00, c[1]});
        end
    endtask

    task t_irq;
        pin0(1'b1);
        irq_is(1'b0);
        wr(6'h0C, 8'h01);
        irq_is(1'b1);
        wr(6'h0E, 8'h00);
        irq_is(1'b1);
        wr(6'h06, 8'h00);
        wr(6'h0E, 8'h01);
        wr(6'h06, 8'h80);
        rdc(6'h0E, 8'h01);
        wr(6'h0E, 8'h01);
        rdc(6'h0E, 8'h00);
        irq_is(1'b0);
        channel_is_compare <= 2'h2;
        @(posedge aclk);
        compare_event <= 2'h2;
        @(posedge aclk);
        compare_event <= 2'h0;
        rdc(6'h0E, 8'h02);
        wr(6'h0C, 8'h02);
        irq_is(1'b1);
    endtask

    task t_fast;
        logic [31:0] v;
        wr(6'h12, 8'h55);
        rdc(6'h0E, 8'h02);
        wr(6'h06, 8'h90);
        wr(6'h12, 8'h55);
        rdc(6'h0E, 8'h00);
        irq_is(1'b0);
        pin0(1'b0);
        rdc(6'h0E, 8'h01);
        rd(6'h10, v);
        rdc(6'h0E, 8'h00);
        wr(6'h06, 8'h80);
        wr(6'h0C, 8'h00);
        channel_is_compare <= 2'h0;
    endtask

    // one wrap at divide by one is the longest wait of the run
    task t_wrap;
        logic [31:0] v;
        int n;
        wr(6'h0D, 8'h80);
        n = 0;
        while (!irq_reg && n < 'h11170) begin
            @(posedge aclk);
            n++;
        end
        irq_is(1'b1);
        rdc(6'h0F, 8'h80);
        wr(6'h0D, 8'h00);
        irq_is(1'b0);
        wr(6'h0D, 8'h80);
        rd(6'h05, v);
        rdc(6'h0F, 8'h80);
        wr(6'h0F, 8'h00);
        rdc(6'h0F, 8'h80);
        wr(6'h06, 8'h00);
        wr(6'h0F, 8'h80);
        rdc(6'h0F, 8'h80);
        wr(6'h06, 8'h80);
        wr(6'h0F, 8'h80);
        rdc(6'h0F, 8'h00);
        irq_is(1'b0);
    endtask

    // read-to-read spacing is 800 cycles, so divide by 8 gives 100 counts
    // new divider waits up to 128 cycles for the stages to reach zero
    task t_div;
        logic [31:0] a, b;
        logic [7:0] d;
        wr(6'h0D, 8'h03);
        repeat (140) @(posedge aclk);
        rd(6'h05, a);
        repeat (797) @(posedge aclk);
        rd(6'h05, b);
        d = b[7:0] - a[7:0];
        chk({31'h0, d >= 8'h63 && d <= 8'h65}, 32'h1, "divide by eight");
        wr(6'h06, 8'h00);
        rd(6'h05, a);
        repeat (50) @(posedge aclk);
        rd(6'h05, b);
        chk(b, a, "stopped counter");
    endtask

    // fine mode can only be chosen by the first control write after a reset
    task t_fine;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        wr(6'h06, 8'h88);
        wr(6'h06, 8'h80);
        rdc(6'h06, 8'h88);
        repeat (5) begin
            @(posedge aclk);
            fine_tick <= 1'b1;
            @(posedge aclk);
            fine_tick <= 1'b0;
        end
        rdc(6'h05, 8'h05);
    endtask

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_edges;
        t_irq;
        t_fast;
        t_wrap;
        t_div;
        t_fine;
        complete_run;
    end
endmodule

bind tmr_top tmr_chk tmr_chk_inst (.*);
